/* File: dv/mem_model.sv */
// Memory partner: grants requests, returns load data one cycle later
// Assumes one request held until granted; slow spaces grants 4 cycles
`timescale 1ns/1ns
module mem_model (
  // Clock, reset and pacing
  input wire logic clk,
  input wire logic resetn,
  input wire logic slow,
  // Memory port of the block
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [23:0] mem_addr,
  input wire logic [63:0] mem_wdata,
  output logic mem_gnt,
  output logic mem_rvalid,
  output logic [63:0] mem_rdata
);
  logic [63:0] mem [0:255];
  logic [1:0] gap;
  assign mem_gnt = mem_req && (!slow || gap == 2'h0);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gap <= 2'h0;
      mem_rvalid <= 1'b0;
      mem_rdata <= '0;
    end else begin
      gap <= mem_gnt ? 2'h3 : (gap == 2'h0 ? 2'h0 : gap - 2'h1);
      mem_rvalid <= mem_gnt && !mem_we;
      mem_rdata <= (mem_gnt && !mem_we) ? mem[mem_addr[7:0]] : ~mem_rdata;
    end
  end
  always @(posedge clk) begin
    if (mem_gnt && mem_we) mem[mem_addr[7:0]] <= mem_wdata;
  end
  initial begin
    for (int n = 0; n < 256; n++) mem[n] = 64'h5a00_0000_0000_0000 + 64'(n);
  end
endmodule : mem_model

/* File: dv/tb_top.sv */
// Self-checking bench for the vector operation block
// Assumes the package, the design and mem_model are compiled first
`timescale 1ns/1ns
`include "vector_ops_defs.svh"
module tb_top;
  import vector_ops_pkg::*;
  localparam logic [63:0] one_f = 64'h4001_8000_0000_0000;
  localparam logic [63:0] two_f = 64'h4002_8000_0000_0000;
  logic clk, resetn, psel, penable, pwrite, pready, pslverr, slow, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic issue_valid, issue_ready, scalar_reserved, mask_write_issue, logical_unit_busy;
  opcode_type issue_code;
  logic [2:0] issue_i, issue_j, issue_k;
  logic [63:0] scalar_operand, element_mask, mem_wdata, mem_rdata, v;
  logic [63:0] t_dr, t_cs, t_mr, t_m7;
  logic [7:0] vreg_reserved;
  logic dest_ready, chain_slot, mask_ready, mask_ready_073;
  logic mem_req, mem_we, mem_gnt, mem_rvalid;
  logic [23:0] mem_addr;
  int n_mismatch = 0;
  int check_count = 0;
  vector_fp_mask_memory_ops vector_fp_mask_memory_ops_inst (.clk, .resetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .issue_valid, .issue_ready,
    .issue_code, .issue_i, .issue_j, .issue_k, .scalar_operand, .vreg_reserved,
    .scalar_reserved, .mask_write_issue, .logical_unit_busy, .dest_ready, .chain_slot,
    .mask_ready, .mask_ready_073, .element_mask, .mem_req, .mem_we, .mem_addr, .mem_wdata,
    .mem_gnt, .mem_rvalid, .mem_rdata);
  mem_model mem_model_inst (.clk, .resetn, .slow, .mem_req, .mem_we, .mem_addr, .mem_wdata,
    .mem_gnt, .mem_rvalid, .mem_rdata);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input string s, input logic [63:0] e, input logic [63:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'h0;
  endtask : apb
  task automatic setv(input logic [2:0] r, input logic [5:0] e, input logic [63:0] d);
    apb(1'b1, `REG_VSEL, {23'h0, r, e});
    apb(1'b1, `REG_VDATA_LO, d[31:0]);
    apb(1'b1, `REG_VDATA_HI, d[63:32]);
  endtask : setv
  task automatic getv(input logic [2:0] r, input logic [5:0] e);
    apb(1'b1, `REG_VSEL, {23'h0, r, e});
    apb(1'b0, `REG_VDATA_LO, 32'h0);
    v[31:0] = rd;
    apb(1'b0, `REG_VDATA_HI, 32'h0);
    v[63:32] = rd;
  endtask : getv
  task automatic issue(input opcode_type c, input logic [2:0] i, j, k, input logic [6:0] len);
    apb(1'b1, `REG_LEN, {25'h0, len});
    @(posedge clk);
    issue_code <= c;
    {issue_i, issue_j, issue_k, issue_valid} <= {i, j, k, 1'b1};
    do @(posedge clk); while (issue_ready !== 1'b1);
    issue_valid <= 1'b0;
    scalar_operand <= ~scalar_operand;
    {t_dr, t_cs, t_mr, t_m7} = '0;
    for (int n = 1; n < 300; n++) begin
      @(posedge clk);
      if (dest_ready === 1'b1) t_dr = 64'(n);
      if (chain_slot === 1'b1) t_cs = 64'(n);
      if (mask_ready === 1'b1) t_mr = 64'(n);
      if (mask_ready_073 === 1'b1) t_m7 = 64'(n);
      if (issue_ready === 1'b1 && n > 1) break;
    end
  endtask : issue
  task automatic t_regs;
    apb(1'b0, `REG_LEN, 32'h0);
    chk("vl reset", 64'h40, {32'h0, rd});
    apb(1'b0, 12'h100, 32'h0);
    chk("unmapped err", 64'h1, {63'h0, err});
    $display("test regs done");
  endtask : t_regs
  task automatic t_hold;
    @(posedge clk);
    issue_code <= OP_ADD_V;
    {issue_i, vreg_reserved} <= {3'h2, 8'h04};
    @(posedge clk);
    chk("dest hold", 64'h0, {63'h0, issue_ready});
    issue_code <= OP_MASK;
    {vreg_reserved, logical_unit_busy} <= {8'h00, 1'b1};
    @(posedge clk);
    chk("logic hold", 64'h0, {63'h0, issue_ready});
    {logical_unit_busy, mask_write_issue} <= 2'h1;
    @(posedge clk);
    mask_write_issue <= 1'b0;
    repeat (3) begin
      chk("mask hold", 64'h0, {63'h0, issue_ready});
      @(posedge clk);
    end
    repeat (3) @(posedge clk);
    chk("mask free", 64'h1, {63'h0, issue_ready});
    $display("test hold done");
  endtask : t_hold
  task automatic fop(input opcode_type c, input logic [2:0] i, j, input logic [63:0] e);
    issue(c, i, j, 3'h1, 7'h2);
    chk("add ready", 64'hd, t_dr);
    chk("add chain", 64'h8, t_cs);
    for (int n = 0; n < 2; n++) begin
      getv(i, n[5:0]);
      chk("add result", e, v);
    end
  endtask : fop
  task automatic t_fadd;
    setv(3'h1, 6'h0, one_f);
    setv(3'h1, 6'h1, 64'h4002_4000_0000_0000);
    fop(OP_ADD_S, 3'h2, 3'h0, one_f);
    fop(OP_SUB_S, 3'h2, 3'h0, {1'b1, one_f[62:0]});
    @(posedge clk);
    scalar_operand <= one_f;
    fop(OP_ADD_S, 3'h3, 3'h3, two_f);
    fop(OP_ADD_V, 3'h3, 3'h1, two_f);
    fop(OP_SUB_V, 3'h4, 3'h3, one_f);
    $display("test fadd done");
  endtask : t_fadd
  task automatic t_pop;
    setv(3'h1, 6'h0, 64'hf0f0_0000_0000_0001);
    setv(3'h1, 6'h1, 64'h3);
    for (int k = 1; k < 3; k++) begin
      issue(OP_RECIP_POP, 3'h2, 3'h1, 3'(k), 7'h2);
      getv(3'h2, 6'h0);
      chk("pop el0", k == 1 ? 64'h9 : 64'h1, v);
      getv(3'h2, 6'h1);
      chk("pop el1", k == 1 ? 64'h2 : 64'h0, v);
    end
    setv(3'h1, 6'h0, one_f);
    issue(OP_RECIP_POP, 3'h2, 3'h1, 3'h0, 7'h1);
    chk("recip ready", 64'h15, t_dr);
    chk("recip chain", 64'h10, t_cs);
    getv(3'h2, 6'h0);
    chk("recip el0", one_f, v);
    $display("test pop done");
  endtask : t_pop
  task automatic t_mask;
    logic [63:0] me [4] = '{64'h9000_0000_0000_0000, 64'h6000_0000_0000_0000,
      64'hd000_0000_0000_0000, 64'h2000_0000_0000_0000};
    setv(3'h1, 6'h0, 64'h0);
    setv(3'h1, 6'h1, 64'h5);
    setv(3'h1, 6'h2, 64'h8000_0000_0000_0001);
    setv(3'h1, 6'h3, 64'h0);
    setv(3'h1, 6'h4, 64'h0);
    for (int k = 0; k < 4; k++) begin
      issue(OP_MASK, 3'h0, 3'h1, {1'b1, 2'(k)}, 7'h4);
      chk("mask", me[k], element_mask);
      chk("mask ready", 64'h8, t_mr);
      chk("mask 073", 64'ha, t_m7);
    end
    $display("test mask done");
  endtask : t_mask
  task automatic t_mem;
    apb(1'b1, `REG_BASE, 32'h10);
    issue(OP_LOAD, 3'h5, 3'h0, 3'h0, 7'h6);
    chk("load ready", 64'hf, t_dr);
    for (int e = 0; e < 6; e++) begin
      getv(3'h5, e[5:0]);
      chk("load data", 64'h5a00_0000_0000_0010 + 64'(e), v);
    end
    apb(1'b1, `REG_BASE, 32'h80);
    apb(1'b1, `REG_STRIDE, 32'h00ff_fffe);
    @(posedge clk);
    slow <= 1'b1;
    issue(OP_STORE, 3'h0, 3'h5, 3'h2, 7'h6);
    for (int e = 0; e < 6; e++) begin
      v = mem_model_inst.mem[8'h80 - 8'(2 * e)];
      chk("store data", 64'h5a00_0000_0000_0010 + 64'(e), v);
    end
    $display("test mem done");
  endtask : t_mem
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results
  initial begin
    {psel, penable, pwrite, paddr, pwdata, issue_valid} = '0;
    issue_code = OP_ADD_S;
    {issue_i, issue_j, issue_k, vreg_reserved} = '0;
    {scalar_reserved, mask_write_issue, logical_unit_busy, slow} = '0;
    scalar_operand = '1;
    resetn = 1'b0;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs;
    t_hold;
    t_fadd;
    t_pop;
    t_mask;
    t_mem;
    results;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    results;
  end
endmodule : tb_top

/* File: include/vector_ops_defs.svh */
// Constants for the vector add, reciprocal, mask and memory block
// Assumes inclusion by the design file and the bench
`ifndef VECTOR_OPS_DEFS_SVH
`define VECTOR_OPS_DEFS_SVH
// Register byte offsets
`define REG_LEN 12'h000
`define REG_STRIDE 12'h004
`define REG_BASE 12'h008
`define REG_STATUS 12'h00c
`define REG_MASK_LO 12'h010
`define REG_MASK_HI 12'h014
`define REG_VSEL 12'h018
`define REG_VDATA_LO 12'h01c
`define REG_VDATA_HI 12'h020
// Reset values
`define LEN_RESET 7'h40
// Times in clock periods of 50 ns; one count per cycle
`define SHORT_LEN 8'h05
`define FADD_READY_MIN 8'h0d
`define FADD_READY_ADD 8'h08
`define FADD_CHAIN 8'h08
`define RECIP_READY_MIN 8'h15
`define RECIP_READY_ADD 8'h10
`define RECIP_CHAIN 8'h10
`define POP_READY_MIN 8'h0d
`define POP_READY_ADD 8'h08
`define POP_CHAIN 8'h08
`define LOAD_READY_MIN 8'h0e
`define LOAD_READY_ADD 8'h09
`define LOAD_CHAIN 8'h09
`define UNIT_BUSY_ADD 8'h04
`define MASK_READY_ADD 8'h04
`define MASK_073_ADD 8'h06
`define STORE_DONE_ADD 8'h05
`define MASK_HOLD_CPS 2'h3
// Floating word layout: sign 63, exponent 62:48, fraction 47:0
`define FP_RECIP_EXP 15'h0001
`endif

/* File: include/vector_ops_pkg.sv */
// Types shared by the vector operation block
// Assumes no other package
package vector_ops_pkg;
  typedef enum logic [2:0] {
    OP_ADD_S = 3'h0, OP_ADD_V = 3'h1, OP_SUB_S = 3'h2, OP_SUB_V = 3'h3,
    OP_RECIP_POP = 3'h4, OP_MASK = 3'h5, OP_LOAD = 3'h6, OP_STORE = 3'h7
  } opcode_type;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0, ST_RUN = 2'h1, ST_DRAIN = 2'h3
  } walk_state_type;
  typedef enum logic [1:0] {
    MT_ZERO = 2'h0, MT_NONZERO = 2'h1, MT_POS = 2'h2, MT_NEG = 2'h3
  } mask_test_type;
endpackage : vector_ops_pkg

/* File: rtl/vector_fp_mask_memory_ops.sv */
// Vector floating add, reciprocal, population count, mask and strided memory
// Assumes an issue controller, an APB master and a memory with grant and read valid
`timescale 1ns/1ns
`include "vector_ops_defs.svh"
// Function
// - Add for low codes 0,1, subtract for 2,3; even codes use the scalar.
// - Process vector length elements from element 0, one step each, into destination.
// - Add and subtract results always come out normalized.
// - Scalar copy is captured once and held for the whole operation.
// - Scalar designator zero means scalar zero, giving normalized pass or negate.
// - Add ready at 13 or length plus 8; chain slot at 8.
// - Add unit busy length plus 4; issue held on busy or reservations.
// - Code 4 function 0 gives reciprocal approximations accurate to 30 bits.
// - Reciprocal assumes top fraction bit set and never checks it.
// - Reciprocal ready at 21 or length plus 16; chain slot at 16.
// - Function 1 writes each element's one-bit count into low 7 bits.
// - Function 2 writes only the count parity into the least significant bit.
// - Code 4 marks shared unit busy length plus 4, holding later code 4.
// - Mask has one bit per element, element 0 at the top bit.
// - Low two k bits pick zero, nonzero, positive or negative test.
// - Top bit clear counts positive, so zero is positive.
// - Only the first length elements are tested; other mask bits clear.
// - Mask usable at length plus 4, or length plus 6 for code 073.
// - Mask issue held 3 cycles after mask write and while logical unit busy.
// - Load reads length words from base, stepping by stride, into elements.
// - Store writes length elements to memory from base, stepping by stride.
// - Stride is signed 22 bits, top bits ignored, designator zero means one.
// - Load ready at 14 or length plus 9 without bank conflicts.
module vector_fp_mask_memory_ops #(
  parameter int ADDR_W = 24
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Issue control
  input wire logic issue_valid,
  output logic issue_ready,
  input wire vector_ops_pkg::opcode_type issue_code,
  input wire logic [2:0] issue_i,
  input wire logic [2:0] issue_j,
  input wire logic [2:0] issue_k,
  input wire logic [63:0] scalar_operand,
  input wire logic [7:0] vreg_reserved,
  input wire logic scalar_reserved,
  input wire logic mask_write_issue,
  input wire logic logical_unit_busy,
  // Completion timing
  output logic dest_ready,
  output logic chain_slot,
  output logic mask_ready,
  output logic mask_ready_073,
  output logic [63:0] element_mask,
  // Memory
  output logic mem_req,
  output logic mem_we,
  output logic [ADDR_W-1:0] mem_addr,
  output logic [63:0] mem_wdata,
  input wire logic mem_gnt,
  input wire logic mem_rvalid,
  input wire logic [63:0] mem_rdata
);
  import vector_ops_pkg::*;

  function automatic logic [63:0] fp_add(input logic [63:0] a, input logic [63:0] b);
    logic [63:0] x;
    logic [63:0] y;
    logic [14:0] e;
    logic [14:0] d;
    logic [49:0] fy;
    logic [49:0] s;
    logic sg;
    x = (a[62:48] >= b[62:48]) ? a : b;
    y = (a[62:48] >= b[62:48]) ? b : a;
    e = x[62:48];
    d = x[62:48] - y[62:48];
    fy = (d > 15'd49) ? 50'h0 : ({2'h0, y[47:0]} >> d);
    sg = x[63];
    if (x[63] == y[63]) begin
      s = {2'h0, x[47:0]} + fy;
    end else if ({2'h0, x[47:0]} >= fy) begin
      s = {2'h0, x[47:0]} - fy;
    end else begin
      s = fy - {2'h0, x[47:0]};
      sg = y[63];
    end
    if (s[48]) begin
      s = s >> 1;
      e = e + 15'd1;
    end
    for (int n = 0; n < 48; n++) begin
      if (!s[47] && s != 50'h0) begin
        s = s << 1;
        e = e - 15'd1;
      end
    end
    return (s == 50'h0) ? 64'h0 : {sg, e, s[47:0]};
  endfunction : fp_add

  function automatic logic [63:0] fp_recip(input logic [63:0] a);
    logic [96:0] q;
    logic [48:0] r;
    logic [14:0] e;
    q = {1'b1, 96'h0} / {49'h0, 1'b1, a[46:0]};
    r = q[49:1];
    e = `FP_RECIP_EXP - a[62:48];
    if (r[48]) begin
      r = {2'h1, 47'h0};
      e = e + 15'd1;
    end
    return {a[63], e, r[47:0]};
  endfunction : fp_recip

  function automatic logic [6:0] pop_count(input logic [63:0] a);
    logic [6:0] c;
    c = 7'h0;
    for (int n = 0; n < 64; n++) begin
      c = c + {6'h0, a[n]};
    end
    return c;
  endfunction : pop_count

  logic rst_meta;
  logic rst_n;
  logic [63:0] vregs [0:511];
  logic [6:0] vector_length;
  logic [21:0] stride;
  logic [ADDR_W-1:0] base;
  logic [8:0] vsel;
  logic [31:0] vdata_stage;
  walk_state_type walk;
  opcode_type op;
  logic [2:0] op_i;
  logic [2:0] op_j;
  logic [2:0] op_k;
  logic [6:0] op_len;
  logic [63:0] scalar_copy;
  logic [6:0] req_idx;
  logic [6:0] rcv_idx;
  logic [ADDR_W-1:0] addr;
  logic [ADDR_W-1:0] stride_eff;
  logic active;
  logic ready_sent;
  logic [7:0] cnt;
  logic [1:0] mask_hold;
  logic issue_fire;
  logic step;
  logic wr_en;
  logic [8:0] wr_addr;
  logic [63:0] wr_data;
  logic [63:0] rd_j;
  logic [63:0] rd_k;
  logic [63:0] first_op;
  logic [7:0] lat;
  logic [7:0] chain;
  logic [7:0] len8;
  logic has_dest;
  logic is_recip;
  logic mask_bit;
  logic [7:0] busy_mask;
  logic hold;

  // Reset release through two flip-flops
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // Operand reads
  assign rd_j = vregs[{op_j, req_idx[5:0]}];
  assign rd_k = vregs[{op_k, req_idx[5:0]}];
  // first operand is scalar copy or vector
  assign first_op = op[0] ? rd_j : scalar_copy;
  assign len8 = {1'b0, op_len};
  assign is_recip = (op == OP_RECIP_POP) && (op_k[1:0] == 2'h0);

  // Latency per operation
  always_comb begin
    lat = 8'h0;
    chain = 8'hff;
    has_dest = 1'b1;
    unique case (op)
      OP_ADD_S, OP_ADD_V, OP_SUB_S, OP_SUB_V: begin
        lat = (len8 <= `SHORT_LEN) ? `FADD_READY_MIN : len8 + `FADD_READY_ADD;
        chain = `FADD_CHAIN;
      end
      OP_RECIP_POP: begin
        if (is_recip) begin
          lat = (len8 <= `SHORT_LEN) ? `RECIP_READY_MIN : len8 + `RECIP_READY_ADD;
          chain = `RECIP_CHAIN;
        end else begin
          lat = (len8 <= `SHORT_LEN) ? `POP_READY_MIN : len8 + `POP_READY_ADD;
          chain = `POP_CHAIN;
        end
      end
      OP_LOAD: begin
        lat = (len8 <= `SHORT_LEN) ? `LOAD_READY_MIN : len8 + `LOAD_READY_ADD;
        chain = `LOAD_CHAIN;
      end
      OP_MASK: begin
        lat = len8 + `MASK_073_ADD;
        has_dest = 1'b0;
      end
      OP_STORE: begin
        lat = len8 + `STORE_DONE_ADD;
        has_dest = 1'b0;
      end
    endcase
  end

  // mask test by low k bits
  always_comb begin
    unique case (mask_test_type'(op_k[1:0]))
      MT_ZERO: mask_bit = (rd_j == 64'h0);
      MT_NONZERO: mask_bit = (rd_j != 64'h0);
      // sign bit decides, zero is positive
      MT_POS: mask_bit = !rd_j[63];
      MT_NEG: mask_bit = rd_j[63];
    endcase
  end

  // issue holds for busy unit and reservations
  always_comb begin
    unique case (issue_code)
      OP_ADD_S, OP_SUB_S: hold = vreg_reserved[issue_i] || vreg_reserved[issue_k]
                               || scalar_reserved;
      OP_ADD_V, OP_SUB_V: hold = vreg_reserved[issue_i] || vreg_reserved[issue_k]
                               || vreg_reserved[issue_j];
      OP_RECIP_POP: hold = vreg_reserved[issue_i] || vreg_reserved[issue_j];
      OP_MASK: hold = vreg_reserved[issue_j] || logical_unit_busy
                    || mask_write_issue || (mask_hold != 2'h0);
      OP_LOAD: hold = vreg_reserved[issue_i];
      OP_STORE: hold = vreg_reserved[issue_j];
    endcase
  end
  assign issue_ready = !active && !hold;
  assign issue_fire = issue_valid && issue_ready;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_hold <= 2'h0;
    end else if (mask_write_issue) begin
      mask_hold <= `MASK_HOLD_CPS;
    end else if (mask_hold != 2'h0) begin
      mask_hold <= mask_hold - 2'h1;
    end
  end

  // Latched operation; scalar copied once at issue
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      op <= OP_ADD_S;
      op_i <= 3'h0;
      op_j <= 3'h0;
      op_k <= 3'h0;
      op_len <= 7'h0;
      scalar_copy <= 64'h0;
      stride_eff <= '0;
    end else if (issue_fire) begin
      op <= issue_code;
      op_i <= issue_i;
      op_j <= issue_j;
      op_k <= issue_k;
      op_len <= vector_length;
      // designator zero gives a zero scalar
      scalar_copy <= (issue_j == 3'h0) ? 64'h0 : scalar_operand;
      // signed 22-bit stride, zero designator means one
      stride_eff <= (issue_k == 3'h0) ? ADDR_W'(1) : ADDR_W'(signed'(stride));
    end
  end

  // Element walker
  assign step = (walk == ST_RUN) && (((op != OP_LOAD) && (op != OP_STORE)) || mem_gnt);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      walk <= ST_IDLE;
      req_idx <= 7'h0;
      rcv_idx <= 7'h0;
      addr <= '0;
    end else if (issue_fire) begin
      walk <= (vector_length != 7'h0) ? ST_RUN : ST_IDLE;
      req_idx <= 7'h0;
      rcv_idx <= 7'h0;
      addr <= base;
    end else begin
      if (step) begin
        req_idx <= req_idx + 7'h1;
        addr <= addr + stride_eff;
        if (req_idx == op_len - 7'h1) begin
          walk <= (op == OP_LOAD) ? ST_DRAIN : ST_IDLE;
        end
      end
      if (mem_rvalid && (op == OP_LOAD)) begin
        rcv_idx <= rcv_idx + 7'h1;
      end
      if (walk == ST_DRAIN && rcv_idx == op_len) begin
        walk <= ST_IDLE;
      end
    end
  end

  // store drives source elements to memory
  assign mem_req = (walk == ST_RUN) && ((op == OP_LOAD) || (op == OP_STORE));
  assign mem_we = (op == OP_STORE);
  assign mem_addr = addr;
  assign mem_wdata = rd_j;

  // Result write port
  always_comb begin
    wr_en = 1'b0;
    wr_addr = {op_i, req_idx[5:0]};
    wr_data = 64'h0;
    if (op == OP_LOAD) begin
      wr_en = mem_rvalid;
      wr_addr = {op_i, rcv_idx[5:0]};
      wr_data = mem_rdata;
    end else if (step) begin
      unique case (op)
        OP_ADD_S, OP_ADD_V: begin
          wr_en = 1'b1;
          wr_data = fp_add(first_op, rd_k);
        end
        OP_SUB_S, OP_SUB_V: begin
          wr_en = 1'b1;
          wr_data = fp_add(first_op, {~rd_k[63], rd_k[62:0]});
        end
        OP_RECIP_POP: begin
          wr_en = 1'b1;
          unique case (op_k[1:0])
            2'h0: wr_data = fp_recip(rd_j);
            2'h1: wr_data = {57'h0, pop_count(rd_j)};
            default: wr_data = {63'h0, ^rd_j};
          endcase
        end
        default: wr_en = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (wr_en) begin
      vregs[wr_addr] <= wr_data;
    end else if (!active && psel && penable && pwrite && paddr == `REG_VDATA_HI) begin
      vregs[vsel] <= {pwdata, vdata_stage};
    end
  end

  // mask cleared at issue, tested bits set
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      element_mask <= 64'h0;
    end else if (issue_fire && issue_code == OP_MASK) begin
      element_mask <= 64'h0;
    end else if (step && op == OP_MASK) begin
      element_mask[6'h3f - req_idx[5:0]] <= mask_bit;
    end
  end

  // Timing counter and completion pulses
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      active <= 1'b0;
      ready_sent <= 1'b0;
      cnt <= 8'h0;
    end else if (issue_fire) begin
      active <= 1'b1;
      ready_sent <= 1'b0;
      cnt <= 8'h1;
    end else if (active) begin
      if (cnt != 8'hff) begin
        cnt <= cnt + 8'h1;
      end
      if (dest_ready) begin
        ready_sent <= 1'b1;
        active <= 1'b0;
      end
      if (!has_dest && walk == ST_IDLE && cnt >= lat) begin
        active <= 1'b0;
      end
    end
  end
  assign dest_ready = active && has_dest && !ready_sent && walk == ST_IDLE && cnt >= lat;
  assign chain_slot = active && cnt == chain;
  assign mask_ready = active && op == OP_MASK && cnt == len8 + `MASK_READY_ADD;
  assign mask_ready_073 = active && op == OP_MASK && cnt == len8 + `MASK_073_ADD;
  // unit busy for length plus 4
  assign busy_mask = len8 + `UNIT_BUSY_ADD;

  // APB registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vector_length <= `LEN_RESET;
      stride <= 22'h0;
      base <= '0;
      vsel <= 9'h0;
      vdata_stage <= 32'h0;
    end else if (psel && penable && pwrite) begin
      unique case (paddr)
        `REG_LEN: vector_length <= pwdata[6:0];
        `REG_STRIDE: stride <= pwdata[21:0];
        `REG_BASE: base <= pwdata[ADDR_W-1:0];
        `REG_VSEL: vsel <= pwdata[8:0];
        `REG_VDATA_LO: vdata_stage <= pwdata;
        default: vdata_stage <= vdata_stage;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0;
    end else if (psel && !penable) begin
      unique case (paddr)
        `REG_LEN: prdata <= {25'h0, vector_length};
        `REG_STRIDE: prdata <= {10'h0, stride};
        `REG_BASE: prdata <= 32'(base);
        `REG_STATUS: prdata <= {27'h0,
          active && op == OP_MASK && cnt < busy_mask,
          active && op == OP_RECIP_POP && cnt < busy_mask,
          active && !op[2] && cnt < busy_mask,
          walk != ST_IDLE, active};
        `REG_MASK_LO: prdata <= element_mask[31:0];
        `REG_MASK_HI: prdata <= element_mask[63:32];
        `REG_VSEL: prdata <= {23'h0, vsel};
        `REG_VDATA_LO: prdata <= vregs[vsel][31:0];
        `REG_VDATA_HI: prdata <= vregs[vsel][63:32];
        default: prdata <= 32'h0;
      endcase
    end
  end
  assign pready = 1'b1;
  assign pslverr = psel && penable && (paddr > `REG_VDATA_HI || paddr[1:0] != 2'h0);

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence short_issue_s(opcode_type c);
    issue_fire && issue_code == c && vector_length <= 7'h5;
  endsequence
  fadd_ready_a: assert property (short_issue_s(OP_ADD_V) |-> ##13 dest_ready)
    else $error("add result not ready at 13");
  fadd_chain_a: assert property (short_issue_s(OP_SUB_S) |-> ##8 chain_slot)
    else $error("add chain slot not at 8");
  recip_ready_a: assert property (short_issue_s(OP_RECIP_POP) && issue_k[1:0] == 2'h0
    |-> ##21 dest_ready)
    else $error("reciprocal not ready at 21");
  issue_hold_a: assert property (active || (vreg_reserved[issue_i]
    && issue_code inside {OP_ADD_S, OP_ADD_V, OP_SUB_S, OP_SUB_V, OP_RECIP_POP, OP_LOAD})
    |-> !issue_ready)
    else $error("issue allowed while unit busy or destination reserved");
  scalar_held_a: assert property (active && $past(active) |-> $stable(scalar_copy))
    else $error("scalar copy changed mid operation");
  first_elem_a: assert property (issue_fire |=> req_idx == 7'h0)
    else $error("operation did not start at element 0");
  mask_hold_a: assert property (mask_write_issue ##1 issue_code == OP_MASK
    |-> !issue_ready)
    else $error("mask issued right after mask write");
  pop_width_a: assert property (wr_en && op == OP_RECIP_POP && op_k[1:0] == 2'h1
    |-> wr_data[63:7] == 57'h0)
    else $error("population count above low bits");
  parity_a: assert property (wr_en && op == OP_RECIP_POP && op_k[1:0] == 2'h2
    |-> wr_data[63:1] == 63'h0)
    else $error("parity result not single bit");
  mask_untested_a: assert property (mask_ready
    |-> (element_mask & ({64{1'b1}} >> op_len)) == 64'h0)
    else $error("untested mask bits set");
  stride_one_a: assert property (issue_fire && issue_k == 3'h0
    |=> stride_eff == ADDR_W'(1))
    else $error("zero stride designator not one");
endmodule : vector_fp_mask_memory_ops
